/* verilog/twras_map.vh */
`ifndef TWRAS_MAP_VH
`define TWRAS_MAP_VH

// default and alternate 8-bit address bytes (write form, bit 0 clear)
`define TWRAS_DEV_ADDR_DEF 8'h20
`define TWRAS_DEV_ADDR_ALT 8'h30

// field positions inside the address/direction byte
`define TWRAS_DEV_MSB 7
`define TWRAS_DEV_LSB 1
`define TWRAS_DIR_BIT 0
`define TWRAS_DIR_READ 1'b1

// byte and acknowledge slot counting
`define TWRAS_CNT_W 4
`define TWRAS_CNT_ZERO 4'h0
`define TWRAS_CNT_ONE 4'h1
`define TWRAS_CNT_ACK 4'h8
`define TWRAS_CNT_DONE 4'h9
`define TWRAS_BYTE_MSB 7
`define TWRAS_BIT_NEXT 6

// internal register address
`define TWRAS_ADDR_W 16
`define TWRAS_ADDR_RST 16'h0000
`define TWRAS_ADDR_INC 16'h0001
`define TWRAS_BYTE_RST 8'h00

// synchroniser lanes
`define TWRAS_SYNC_W 4
`define TWRAS_LN_SCL 0
`define TWRAS_LN_SDA 1
`define TWRAS_LN_SEL 2
`define TWRAS_LN_SEN 3

`endif

/* verilog/twras_sync.v */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser, one lane per asynchronous pin
module twras_sync #(
	parameter WIDTH = 4
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// raw pins and their synchronised copies
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar i;

	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
			reg meta_r; // first stage, read only by second stage
			reg sync_r; // second stage, safe to use

			// lines idle high, so reset to high avoids a false start
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else begin
					meta_r <= async_in[i];
					sync_r <= meta_r;
				end
			end

			assign sync_out[i] = sync_r;
		end
	endgenerate

endmodule // twras_sync

`default_nettype wire

/* verilog/twras_slave.v */
// What this block does
// - load address from dummy write, advance per read
// - bare read uses current internal address
// - keep sending bytes while host acknowledges
// - store data byte at addressed register
// - sequential write bytes go to next addresses
// - byte bits 7..1 address, bit 0 direction
// - answer 0x20/0x21, or 0x30/0x31 when selected
// - increment internal address after every data byte read or written
// - serial clock is input only, never driven
`timescale 1ns/1ps
`default_nettype none
`include "twras_map.vh"

module twras_slave (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// two-wire bus pins, clock is input only
	input wire serial_clock_in,
	input wire serial_data_line_in,
	output reg serial_data_line_out,
	output reg serial_data_line_oe,
	// alternate address selection pins
	input wire address_select_input,
	input wire address_select_enable,
	// register file side
	output reg [15:0] reg_addr_r,
	output reg reg_wr_en_r,
	output reg [7:0] reg_wr_data_r,
	output reg reg_rd_en_r,
	input wire [7:0] reg_rd_data
);

	// one-hot states
	localparam [5:0] ST_IDLE = 6'h01; // ignoring the bus
	localparam [5:0] ST_DEV = 6'h02; // receiving address/direction byte
	localparam [5:0] ST_AHI = 6'h04; // receiving high register address
	localparam [5:0] ST_ALO = 6'h08; // receiving low register address
	localparam [5:0] ST_WDAT = 6'h10; // receiving write data
	localparam [5:0] ST_RDAT = 6'h20; // sending read data

	wire [3:0] pins_s; // synchronised pins
	reg scl_d_r; // previous synchronised clock
	reg sda_d_r; // previous synchronised data
	reg [5:0] state_r; // current state
	reg [5:0] pend_r; // state taken at end of ack slot
	reg [3:0] cnt_r; // rising edges seen in this byte
	reg [7:0] rx_r; // receive shift register
	reg [7:0] tx_r; // transmit shift register
	reg [7:0] ahi_r; // high address byte held until low arrives
	reg [15:0] addr_nxt; // next internal address
	reg [7:0] dev_addr; // address this device answers to

	wire scl_s = pins_s[`TWRAS_LN_SCL];
	wire sda_s = pins_s[`TWRAS_LN_SDA];
	wire sel_s = pins_s[`TWRAS_LN_SEL];
	wire sen_s = pins_s[`TWRAS_LN_SEN];

	// bus events, all on synchronised copies
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
	wire dev_hit = (rx_r[`TWRAS_DEV_MSB:`TWRAS_DEV_LSB] ==
		dev_addr[`TWRAS_DEV_MSB:`TWRAS_DEV_LSB]);
	wire dir_rd = (rx_r[`TWRAS_DIR_BIT] == `TWRAS_DIR_READ);

	// pins come from outside the clock domain
	twras_sync #(
		.WIDTH(`TWRAS_SYNC_W)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in({address_select_enable, address_select_input,
			serial_data_line_in, serial_clock_in}),
		.sync_out(pins_s)
	);

	// address selection, alternate only when enabled and asserted
	always @* begin
		if (sen_s & sel_s) begin
			dev_addr = `TWRAS_DEV_ADDR_ALT;
		end else begin
			dev_addr = `TWRAS_DEV_ADDR_DEF;
		end
	end

	// internal address step, wraps at the top
	always @* begin
		addr_nxt = reg_addr_r + `TWRAS_ADDR_INC;
	end

	// edge history for event detection
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// the protocol engine
	// no clock output exists at all, so clock stretching cannot happen
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			pend_r <= ST_IDLE;
			cnt_r <= `TWRAS_CNT_ZERO;
			rx_r <= `TWRAS_BYTE_RST;
			tx_r <= `TWRAS_BYTE_RST;
			ahi_r <= `TWRAS_BYTE_RST;
			reg_addr_r <= `TWRAS_ADDR_RST;
			reg_wr_en_r <= 1'b0;
			reg_wr_data_r <= `TWRAS_BYTE_RST;
			reg_rd_en_r <= 1'b0;
			serial_data_line_out <= 1'b0;
			serial_data_line_oe <= 1'b0;
		end else begin
			// strobes last one cycle
			reg_wr_en_r <= 1'b0;
			reg_rd_en_r <= 1'b0;
			// open drain: the driven level is always low
			serial_data_line_out <= 1'b0;
			if (start_ev | stop_ev) begin
				// drop any partial byte and release the line
				cnt_r <= `TWRAS_CNT_ZERO;
				serial_data_line_oe <= 1'b0;
				if (start_ev) begin
					state_r <= ST_DEV;
					pend_r <= ST_DEV;
				end else begin
					state_r <= ST_IDLE;
					pend_r <= ST_IDLE;
				end
			end else if (scl_rise && (state_r != ST_IDLE)) begin
				if (cnt_r < `TWRAS_CNT_ACK) begin
					// msb first, sampled while clock high
					rx_r <= {rx_r[`TWRAS_BIT_NEXT:0], sda_s};
				end else if (cnt_r == `TWRAS_CNT_ACK && state_r == ST_RDAT) begin
					// host nack ends the read, ack asks for more
					if (sda_s) begin
						pend_r <= ST_IDLE;
					end else begin
						pend_r <= ST_RDAT;
					end
				end
				if (cnt_r != `TWRAS_CNT_DONE) begin
					cnt_r <= cnt_r + `TWRAS_CNT_ONE;
				end
			end else if (scl_fall && (state_r != ST_IDLE)) begin
				if (cnt_r == `TWRAS_CNT_ACK) begin
					// a whole byte has passed; decide the ack slot
					case (state_r)
						ST_DEV: begin
							if (dev_hit) begin
								serial_data_line_oe <= 1'b1;
								// read goes straight to data: current location
								pend_r <= dir_rd ? ST_RDAT : ST_AHI;
							end else begin
								pend_r <= ST_IDLE;
							end
						end
						ST_AHI: begin
							ahi_r <= rx_r;
							serial_data_line_oe <= 1'b1;
							pend_r <= ST_ALO;
						end
						ST_ALO: begin
							// dummy write or write header sets the address
							reg_addr_r <= {ahi_r, rx_r};
							serial_data_line_oe <= 1'b1;
							pend_r <= ST_WDAT;
						end
						ST_WDAT: begin
							reg_wr_en_r <= 1'b1;
							reg_wr_data_r <= rx_r;
							serial_data_line_oe <= 1'b1;
							pend_r <= ST_WDAT;
						end
						ST_RDAT: begin
							// byte delivered: release for host ack, step address
							serial_data_line_oe <= 1'b0;
							reg_addr_r <= addr_nxt;
						end
						default: begin
							pend_r <= ST_IDLE;
						end
					endcase
				end else if (cnt_r == `TWRAS_CNT_DONE) begin
					// ack slot over: next byte begins
					cnt_r <= `TWRAS_CNT_ZERO;
					state_r <= pend_r;
					if (state_r == ST_WDAT) begin
						// step only once the strobe has used the old address
						reg_addr_r <= addr_nxt;
					end
					if (pend_r == ST_RDAT) begin
						// fetch the byte at the internal address, drive its msb
						tx_r <= reg_rd_data;
						reg_rd_en_r <= 1'b1;
						serial_data_line_oe <= ~reg_rd_data[`TWRAS_BYTE_MSB];
					end else begin
						serial_data_line_oe <= 1'b0;
					end
				end else if (state_r == ST_RDAT) begin
					// shift out the next bit while clock low
					tx_r <= {tx_r[`TWRAS_BIT_NEXT:0], 1'b0};
					serial_data_line_oe <= ~tx_r[`TWRAS_BIT_NEXT];
				end
			end
		end
	end

endmodule // twras_slave

`default_nettype wire

/* verification/twras_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// pin and register side checks of the slave
module twras_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bus pins
	input wire logic serial_clock_in,
	input wire logic serial_data_line_in,
	input wire logic serial_data_line_oe,
	input wire logic serial_data_line_out,
	// register side
	input wire logic [15:0] reg_addr_r,
	input wire logic reg_wr_en_r,
	input wire logic [7:0] reg_wr_data_r,
	input wire logic reg_rd_en_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_WR_PULSE: assert property (reg_wr_en_r |=> !reg_wr_en_r) else $error("wr pulse");
	AST_RD_PULSE: assert property (reg_rd_en_r |=> !reg_rd_en_r) else $error("rd pulse");
	AST_WR_ADDR: assert property (reg_wr_en_r |-> $stable(reg_addr_r)) else $error("wr addr");
	AST_WDATA: assert property ($changed(reg_wr_data_r) |-> reg_wr_en_r) else $error("wdata");
	AST_RD_HOLD: assert property (reg_rd_en_r |=> $stable(reg_addr_r) [*8]) else $error("rd addr");
	AST_DRV_LOW: assert property ($rose(serial_data_line_oe) |-> !serial_clock_in)
		else $error("drive at clock high");
	AST_DRV_HOLD: assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe [*8])
		else $error("drive too short");
	AST_OD_LEVEL: assert property (serial_data_line_oe |-> !serial_data_line_out)
		else $error("drive level high");
	AST_FRAME_REL: assert property (serial_clock_in && $changed(serial_data_line_in)
		|-> ##[3:5] !serial_data_line_oe) else $error("no release");
endmodule // twras_chk
bind twras_slave twras_chk u_chk (
	.clk(clk),
	.rst_b(rst_b),
	.serial_clock_in(serial_clock_in),
	.serial_data_line_in(serial_data_line_in),
	.serial_data_line_oe(serial_data_line_oe),
	.serial_data_line_out(serial_data_line_out),
	.reg_addr_r(reg_addr_r),
	.reg_wr_en_r(reg_wr_en_r),
	.reg_wr_data_r(reg_wr_data_r),
	.reg_rd_en_r(reg_rd_en_r)
);
`default_nettype wire

/* verification/twras_master.sv */
`timescale 1ns/1ps
`default_nettype none
// bus master model, clock rests high between frames
module twras_master (
	output var logic scl,
	output var logic sda_o,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end
	// one 160 ns bit slot, data moves only while clock low
	task automatic bitx(input logic b, output logic r);
		sda_o = b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask
	// start or restart
	task automatic start();
		sda_o = 1'b1;
		#40 scl = 1'b1;
		#40 sda_o = 1'b0;
		#40 scl = 1'b0;
		#40;
	endtask
	// stop, then the clock stands still
	task automatic stop();
		sda_o = 1'b0;
		#40 scl = 1'b1;
		#40 sda_o = 1'b1;
		#80;
	endtask
	// msb first, then the ack slot; reads send 8'hff
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(a, k);
	endtask
endmodule // twras_master
`default_nettype wire

/* verification/twras_slave_test.sv */
`timescale 1ns/1ps
`default_nettype none
module twras_slave_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sel = 1'b0;
	logic sen = 1'b0;
	logic [7:0] mem [0:255]; // register file stand-in
	logic [7:0] q;
	logic ack;
	int error_cnt = 0;
	int n_compared = 0;
	int n_rd = 0; // read strobes seen from the slave
	wire logic scl, sda_o, oe, wen, ren, sdo;
	wire logic [15:0] addr;
	wire logic [7:0] wdata;
	// pull-up, open drain: the slave's driven level wins only while enabled
	wire logic sda = oe ? (sda_o & sdo) : sda_o;
	initial forever #4 clk = ~clk;
	twras_master u_mst (.scl(scl), .sda_o(sda_o), .sda(sda));
	twras_slave u_dut (.clk(clk), .rst_b(rst_b), .serial_clock_in(scl), .serial_data_line_in(sda),
		.serial_data_line_out(sdo), .serial_data_line_oe(oe), .address_select_input(sel),
		.address_select_enable(sen), .reg_addr_r(addr), .reg_wr_en_r(wen),
		.reg_wr_data_r(wdata), .reg_rd_en_r(ren), .reg_rd_data(mem[addr[7:0]]));
	always @(posedge clk) if (wen === 1'b1) mem[addr[7:0]] <= wdata;
	// one strobe per delivered read byte, the nacked one included
	always @(posedge clk) if (ren === 1'b1) n_rd <= n_rd + 1;
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wb(logic [7:0] d, logic ea);
		u_mst.xfer(d, 1'b1, q, ack);
		chk("ack", {15'h0000, ack}, {15'h0000, ea});
	endtask
	task automatic rb(logic a, logic [7:0] e);
		u_mst.xfer(8'hff, a, q, ack);
		chk("rdata", {8'h00, q}, {8'h00, e});
	endtask
	// sequential write, then dummy write and two reads
	task automatic t_wr_rd();
		u_mst.start();
		wb(8'h20, 1'b0);
		wb(8'h12, 1'b0);
		wb(8'h34, 1'b0);
		wb(8'ha5, 1'b0);
		wb(8'h5a, 1'b0);
		u_mst.stop();
		chk("mem", {8'h00, mem[8'h35]}, 16'h005a);
		u_mst.start();
		wb(8'h20, 1'b0);
		wb(8'h12, 1'b0);
		wb(8'h34, 1'b0);
		u_mst.start();
		wb(8'h21, 1'b0);
		rb(1'b0, 8'ha5);
		rb(1'b1, 8'h5a);
		u_mst.stop();
		chk("addr", addr, 16'h1236);
	endtask
	// single bit cut by a restart, then a bare read
	task automatic t_cur();
		u_mst.start();
		u_mst.bitx(1'b0, ack);
		u_mst.start();
		wb(8'h21, 1'b0);
		rb(1'b1, 8'hc3);
		u_mst.stop();
		chk("addr", addr, 16'h1237);
	endtask
	// both write-form addresses under every select setting
	task automatic t_sel();
		for (int i = 0; i < 8; i++) begin
			sel = i[0];
			sen = i[1];
			u_mst.start();
			wb(i[2] ? 8'h30 : 8'h20, (i[2] == (i[0] & i[1])) ? 1'b0 : 1'b1);
			u_mst.stop();
		end
	endtask
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'h00;
		mem[8'h36] = 8'hc3;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_wr_rd();
		t_cur();
		chk("reads", n_rd[15:0], 16'h0003);
		t_sel();
		end_of_test();
	end
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule // twras_slave_test
`default_nettype wire
